/* File: core/hpi_map.vh */
// Summary of operation
// - Sync multiplexed mode makes its own chip select, ignoring the pin.
// - Multiplexed mode latches address bits 7..0 on the latch strobe.
// - Multiplexed mode answers only when latched bits 7..3 are zero.
// - Async strobe mode: separate buses, each access ends by ready handshake.
// - Async strobe mode turns the decoder off; the host drives chip select.
// - The single-port RAM is shared between host port and microsequencer.
// - On simultaneous requests the host port wins the RAM.
// - In async modes ready stretches the access until the RAM is done.
// - Host data drivers stay off while reset is asserted.
// - Write pin is low write strobe or E clock, by host family.
// - Read pin is low read strobe or read/write line, by host family.
// - Latch pin is address latch enable for strobe hosts; E-clock modes ignore it.
// - Divided clock output is input clock over 2 or 4 by select pin.
// - Output-float test pin low floats every output and two-way pin.
// - Factory test pin low enters internal test modes.
// - Sync strobe mode uses fixed timing over multiplexed address/data.
// - E-clock modes use the select pin; async uses ready, sync is fixed.
`ifndef HPI_MAP_VH
`define HPI_MAP_VH
`define HPI_MODE_SYNC_STROBE 2'b00
`define HPI_MODE_ASYNC_STROBE 2'b01
`define HPI_MODE_ASYNC_ECLK 2'b10
`define HPI_MODE_SYNC_ECLK 2'b11
`define HPI_ADDR_W 11
`define HPI_DATA_W 8
`define HPI_RAM_DEPTH 1536
`define HPI_MUX_HIGH_MSB 7
`define HPI_MUX_HIGH_LSB 3
`define HPI_RESET_MIN_CYCLES 4
`endif

/* File: core/hpi_sync2.v */
`timescale 1ns/10ps
module hpi_sync2 #(
	parameter W = 1
) (
	input  wire         clock,
	input  wire         rst,
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] stage1_reg;
	reg [W-1:0] stage2_reg;
	// Host strobes are asynchronous to our clock; first stage feeds only the second
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_reg <= {W{1'b1}};
			stage2_reg <= {W{1'b1}};
		end else begin
			stage1_reg <= din;
			stage2_reg <= stage1_reg;
		end
	end
	assign dout = stage2_reg;
endmodule

/* File: core/hpi_clkdiv.v */
`timescale 1ns/10ps
module hpi_clkdiv (
	input  wire clock,
	input  wire rst,
	input  wire divideBy2,
	output wire divClock
);
	reg [1:0] count_reg;
	always @(posedge clock or posedge rst) begin
		if (rst)
			count_reg <= 2'h0;
		else
			count_reg <= count_reg + 2'h1;
	end
	assign divClock = divideBy2 ? count_reg[0] : count_reg[1];
endmodule

/* File: core/hpi_host_port.v */
`timescale 1ns/10ps
`include "hpi_map.vh"
module hpi_host_port #(
	parameter ADDR_W  = `HPI_ADDR_W,
	parameter DATA_W  = `HPI_DATA_W,
	parameter DEPTH   = `HPI_RAM_DEPTH
) (
	input  wire              clock,
	input  wire              rst,
	input  wire              cpuFamilySelect,
	input  wire              syncMode,
	input  wire              dividerSelect,
	input  wire              intPolarityHigh,
	input  wire              outputFloatTest_n,
	input  wire              factoryTest_n,
	input  wire [ADDR_W-1:0] hostAddressBus,
	input  wire [DATA_W-1:0] hostDataIn,
	output reg  [DATA_W-1:0] hostDataOut,
	output reg               hostDataOe,
	input  wire              chipSelect_n,
	input  wire              addressLatchStrobe,
	input  wire              writeStrobeOrEclk,
	input  wire              readStrobeOrDirection,
	output reg               accessReadyOut,
	output reg               accessReadyOe,
	output reg               dividedClockOut,
	output reg               dividedClockOe,
	output reg               interruptOut,
	output reg               interruptOe,
	input  wire              interruptRequest,
	input  wire              seqReq,
	input  wire              seqWrite,
	input  wire [ADDR_W-1:0] seqAddr,
	input  wire [DATA_W-1:0] seqWdata,
	output reg  [DATA_W-1:0] seqRdata,
	output reg               seqAck,
	output reg               factoryTestActive
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RAM  = 2'h1;
	localparam ST_HOLD = 2'h2;

	// Access timing, counted in edges from the strobe edge:
	//   +2  strobes seen through the synchroniser; request taken at +3
	//   +3  RAM cycle, host has the RAM whatever the sequencer wants
	//   +4  hold state entered, read data registered
	//   +5  ready driven low and read data driven onto the pins
	// The strobe must then be released; ready and data stand until the
	// synchronised release is seen, so back-to-back accesses need a gap.
	// Writes land in the RAM cycle; the sequencer is held off for it.
	// Mode straps are assumed static; changing them mid-access is undefined.

	reg  [DATA_W-1:0] ram [0:DEPTH-1];
	reg  [1:0]        mode_reg;
	reg  [1:0]        state_reg;
	reg  [1:0]        state_next;
	reg  [ADDR_W-1:0] addr_reg;
	reg  [7:0]        lowAddr_reg;
	reg               isWrite_reg;
	reg  [DATA_W-1:0] wdata_reg;
	reg  [DATA_W-1:0] rdata_reg;
	wire [3:0]        pinsSync;
	wire              csSync_n;
	wire              aleSync;
	wire              wrSync;
	wire              rdSync;
	wire              divClock;
	wire              muxMode;
	wire              asyncMode;
	wire              internalCs;
	reg               selected;
	reg               wantWrite;
	reg               wantRead;
	reg               aleQuiet;
	wire              active;
	wire              hostRead;
	wire [ADDR_W-1:0] hostAddr;
	wire              hostGrant;
	wire              seqGrant;
	wire              ramWe;
	wire [ADDR_W-1:0] ramAddr;
	wire [DATA_W-1:0] ramWdata;
	wire              ramInRange;

	hpi_sync2 #(.W(4)) u_sync (
		.clock (clock),
		.rst   (rst),
		.din   ({chipSelect_n, addressLatchStrobe,
		         writeStrobeOrEclk, readStrobeOrDirection}),
		.dout  (pinsSync)
	);
	assign csSync_n = pinsSync[3];
	assign aleSync  = pinsSync[2];
	assign wrSync   = pinsSync[1];
	assign rdSync   = pinsSync[0];

	hpi_clkdiv u_div (
		.clock     (clock),
		.rst       (rst),
		.divideBy2 (dividerSelect),
		.divClock  (divClock)
	);

	// Mode pins are static straps; sampling each clock keeps reset constant
	always @(posedge clock or posedge rst) begin
		if (rst)
			mode_reg <= `HPI_MODE_SYNC_STROBE;
		else
			mode_reg <= {cpuFamilySelect, syncMode ~^ cpuFamilySelect};
	end
	// Encoding: 00 sync strobe, 01 async strobe, 10 async eclk, 11 sync eclk
	assign muxMode    = (mode_reg == `HPI_MODE_SYNC_STROBE);
	assign asyncMode  = (mode_reg == `HPI_MODE_ASYNC_STROBE) ||
		(mode_reg == `HPI_MODE_ASYNC_ECLK);

	// Low address latched from the shared data lines
	always @(posedge clock or posedge rst) begin
		if (rst)
			lowAddr_reg <= 8'h00;
		else if (muxMode && aleSync)
			lowAddr_reg <= hostDataIn;
	end

	assign internalCs = (lowAddr_reg[`HPI_MUX_HIGH_MSB:`HPI_MUX_HIGH_LSB]
		== 5'h00);
	assign hostAddr = muxMode ?
		{hostAddressBus[ADDR_W-1:8], lowAddr_reg} : hostAddressBus;
	// Decoder on only in the multiplexed mode, else external chip select.
	// Strobe hosts use low strobes and ALE must have fallen first; in
	// E-clock modes E high qualifies the read/write direction line.
	always @* begin
		selected  = 1'b0;
		wantWrite = 1'b0;
		wantRead  = 1'b0;
		aleQuiet  = 1'b1;
		case (mode_reg)
			`HPI_MODE_SYNC_STROBE: begin
				selected  = internalCs;
				wantWrite = !wrSync;
				wantRead  = !rdSync;
				aleQuiet  = !aleSync;
			end
			`HPI_MODE_ASYNC_STROBE: begin
				selected  = !csSync_n;
				wantWrite = !wrSync;
				wantRead  = !rdSync;
				aleQuiet  = !aleSync;
			end
			`HPI_MODE_ASYNC_ECLK, `HPI_MODE_SYNC_ECLK: begin
				selected  = !csSync_n;
				wantWrite = wrSync && !rdSync;
				wantRead  = wrSync && rdSync;
			end
			default: begin
				selected  = 1'b0;
			end
		endcase
	end
	assign active = selected && (wantWrite || wantRead) && aleQuiet;

	// Host wins when both ports ask in the same cycle
	assign hostGrant = (state_reg == ST_RAM);
	assign hostRead  = (state_reg == ST_HOLD) && !isWrite_reg && wantRead;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (active)
					state_next = ST_RAM;
			end
			ST_RAM: begin
				state_next = ST_HOLD;
			end
			ST_HOLD: begin
				if (!active)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Back to idle only once the synchronised strobe is released
	always @(posedge clock or posedge rst) begin
		if (rst)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Request is frozen when taken so a slow strobe release cannot alter it
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_reg    <= {ADDR_W{1'b0}};
			isWrite_reg <= 1'b0;
			wdata_reg   <= {DATA_W{1'b0}};
		end else if (state_reg == ST_IDLE && active) begin
			addr_reg    <= hostAddr;
			isWrite_reg <= wantWrite;
			wdata_reg   <= hostDataIn;
		end
	end

	// Out-of-range reads return zero rather than aliasing into the RAM
	always @(posedge clock or posedge rst) begin
		if (rst)
			rdata_reg <= {DATA_W{1'b0}};
		else if (hostGrant && !isWrite_reg)
			rdata_reg <= ramInRange ? ram[ramAddr] : {DATA_W{1'b0}};
	end

	// Sequencer is served only in cycles the host leaves free
	assign seqGrant   = seqReq && !hostGrant && !seqAck;
	// One address, one write port: the RAM itself stays single-ported
	assign ramAddr    = hostGrant ? addr_reg : seqAddr;
	assign ramWdata   = hostGrant ? wdata_reg : seqWdata;
	assign ramWe      = hostGrant ? isWrite_reg : (seqGrant && seqWrite);
	assign ramInRange = (ramAddr < DEPTH);

	always @(posedge clock) begin
		if (ramWe && ramInRange)
			ram[ramAddr] <= ramWdata;
	end

	// Sequencer waits a cycle whenever the host holds the RAM
	always @(posedge clock or posedge rst) begin
		if (rst)
			seqAck <= 1'b0;
		else
			seqAck <= seqGrant;
	end

	// Read data stands until the next sequencer read
	always @(posedge clock or posedge rst) begin
		if (rst)
			seqRdata <= {DATA_W{1'b0}};
		else if (seqGrant && !seqWrite)
			seqRdata <= ramInRange ? ram[ramAddr] : {DATA_W{1'b0}};
	end

	// Data drivers only while a read is held and the pins are not floated
	always @(posedge clock or posedge rst) begin
		if (rst)
			hostDataOut <= {DATA_W{1'b0}};
		else
			hostDataOut <= rdata_reg;
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			hostDataOe <= 1'b0;
		else
			hostDataOe <= outputFloatTest_n && hostRead;
	end

	// Ready low once the RAM cycle is done; driven only in async modes
	always @(posedge clock or posedge rst) begin
		if (rst)
			accessReadyOut <= 1'b1;
		else
			accessReadyOut <= !(state_reg == ST_HOLD);
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			accessReadyOe <= 1'b0;
		else
			accessReadyOe <= outputFloatTest_n && selected &&
				asyncMode;
	end

	// Counter runs through test float so the phase stays continuous
	always @(posedge clock or posedge rst) begin
		if (rst)
			dividedClockOut <= 1'b0;
		else
			dividedClockOut <= divClock;
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			dividedClockOe <= 1'b0;
		else
			dividedClockOe <= outputFloatTest_n;
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			interruptOut <= 1'b0;
		else
			interruptOut <= interruptRequest ~^ intPolarityHigh;
	end

	always @(posedge clock or posedge rst) begin
		if (rst)
			interruptOe <= 1'b0;
		else
			interruptOe <= outputFloatTest_n;
	end

	// Test modes beyond this flag are not modelled
	always @(posedge clock or posedge rst) begin
		if (rst)
			factoryTestActive <= 1'b0;
		else
			factoryTestActive <= !factoryTest_n;
	end
endmodule

/* File: bench/hpi_host_port_assertions.sv */
`timescale 1ns/10ps
`include "hpi_map.vh"
module hpi_host_port_chk #(
	parameter DATA_W = 8
) (
	input wire			clock,
	input wire			rst,
	input wire			cpuFamilySelect,
	input wire			syncMode,
	input wire			dividerSelect,
	input wire			intPolarityHigh,
	input wire			outputFloatTest_n,
	input wire			factoryTest_n,
	input wire [DATA_W-1:0]	hostDataIn,
	input wire			hostDataOe,
	input wire			chipSelect_n,
	input wire			addressLatchStrobe,
	input wire			accessReadyOut,
	input wire			accessReadyOe,
	input wire			dividedClockOut,
	input wire			dividedClockOe,
	input wire			interruptOut,
	input wire			interruptOe,
	input wire			interruptRequest,
	input wire			seqReq,
	input wire			seqAck,
	input wire			factoryTestActive
);
	wire [1:0]		mode = {cpuFamilySelect, cpuFamilySelect ~^ syncMode};
	wire			mux = mode == `HPI_MODE_SYNC_STROBE;
	wire			rigid = mux || mode == `HPI_MODE_SYNC_ECLK;
	reg [DATA_W-1:0]	lowAddr_reg;
	always @(posedge clock or posedge rst)
		if (rst)
			lowAddr_reg <= {DATA_W{1'b0}};
		else if (addressLatchStrobe)
			lowAddr_reg <= hostDataIn;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_irq_steady;
		($stable(interruptRequest) && $stable(intPolarityHigh)) [*3];
	endsequence
	property p_reset_quiet;
		disable iff (1'b0)
		rst && $past(rst) |-> !hostDataOe && !accessReadyOe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("bus driven in reset");
	property p_float;
		!outputFloatTest_n |=> !hostDataOe && !accessReadyOe &&
			!dividedClockOe && !interruptOe;
	endproperty
	a_float: assert property (p_float)
		else $error("pin driven while floated");
	property p_rigid;
		rigid && $past(rigid) && $past(rigid, 2) |-> !accessReadyOe;
	endproperty
	a_rigid: assert property (p_rigid)
		else $error("ready in rigid mode");
	property p_ready_cs;
		$fell(accessReadyOut) && accessReadyOe |-> $past(!chipSelect_n, 3);
	endproperty
	a_ready_cs: assert property (p_ready_cs)
		else $error("ready unselected");
	property p_mux_win;
		mux && $rose(hostDataOe) |-> lowAddr_reg[7:3] == 5'h00;
	endproperty
	a_mux_win: assert property (p_mux_win)
		else $error("mux window wrong");
	property p_seq_ack;
		seqAck |-> $past(seqReq);
	endproperty
	a_seq_ack: assert property (p_seq_ack)
		else $error("ack without request");
	property p_div2;
		dividerSelect && $past(dividerSelect) && !$past(rst) &&
			!$past(rst, 2) |-> $changed(dividedClockOut);
	endproperty
	a_div2: assert property (p_div2)
		else $error("divide by 2 wrong");
	property p_div4;
		!dividerSelect && !$past(dividerSelect) && !$past(dividerSelect, 2)
			&& $changed(dividedClockOut) |=> $stable(dividedClockOut);
	endproperty
	a_div4: assert property (p_div4)
		else $error("divide by 4 wrong");
	property p_irq;
		s_irq_steady |-> interruptOut == (interruptRequest == intPolarityHigh);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt polarity wrong");
	property p_test;
		!factoryTest_n [*2] |-> factoryTestActive;
	endproperty
	a_test: assert property (p_test)
		else $error("test mode not entered");
endmodule
bind hpi_host_port hpi_host_port_chk #(.DATA_W(DATA_W)) chk (
	.clock              (clock),
	.rst                (rst),
	.cpuFamilySelect    (cpuFamilySelect),
	.syncMode           (syncMode),
	.dividerSelect      (dividerSelect),
	.intPolarityHigh    (intPolarityHigh),
	.outputFloatTest_n  (outputFloatTest_n),
	.factoryTest_n      (factoryTest_n),
	.hostDataIn         (hostDataIn),
	.hostDataOe         (hostDataOe),
	.chipSelect_n       (chipSelect_n),
	.addressLatchStrobe (addressLatchStrobe),
	.accessReadyOut     (accessReadyOut),
	.accessReadyOe      (accessReadyOe),
	.dividedClockOut    (dividedClockOut),
	.dividedClockOe     (dividedClockOe),
	.interruptOut       (interruptOut),
	.interruptOe        (interruptOe),
	.interruptRequest   (interruptRequest),
	.seqReq             (seqReq),
	.seqAck             (seqAck),
	.factoryTestActive  (factoryTestActive)
);

/* File: bench/hpi_host_model.sv */
`timescale 1ns/10ps
module hpi_host_model (
	input wire		clock,
	input wire		cpuFamilySelect,
	input wire		mux,
	input wire [7:0]	hostDataOut,
	input wire		hostDataOe,
	input wire		accessReadyOut,
	input wire		accessReadyOe,
	output wire [7:0]	hostDataIn,
	output reg [10:0]	hostAddressBus = 0,
	output reg		chipSelect_n = 1,
	output reg		addressLatchStrobe = 0,
	output wire		writeStrobeOrEclk,
	output wire		readStrobeOrDirection
);
	reg [7:0]	drv = 0, last = 0;
	reg		drvOn = 0, act = 0, wrOp = 0;
	// Released bus shows the inverse of its last value, never a stale copy
	assign hostDataIn = hostDataOe ? hostDataOut : drvOn ? drv : ~last;
	assign writeStrobeOrEclk = cpuFamilySelect ? act : !(act && wrOp);
	assign readStrobeOrDirection = cpuFamilySelect ? !wrOp :
		!(act && !wrOp);
	always @(posedge clock)
		last <= hostDataIn;
	task access(input w, input [10:0] a, input [7:0] d, input sel,
		input rdy, output [7:0] q, output ok);
		integer i;
		begin
			ok = 0;
			@(posedge clock);
			hostAddressBus <= a;
			wrOp <= w;
			drv <= a[7:0];
			drvOn <= mux;
			addressLatchStrobe <= mux;
			repeat (3) @(posedge clock);
			addressLatchStrobe <= 1'b0;
			repeat (3) @(posedge clock);
			drv <= d;
			drvOn <= w;
			// Mux hosts tie select high, others decode it outside
			chipSelect_n <= !sel || mux;
			act <= 1'b1;
			for (i = 0; i < 12 && !ok; i = i + 1) begin
				@(posedge clock);
				ok = rdy ? accessReadyOe && !accessReadyOut
					: i == 7;
			end
			q = hostDataIn;
			chipSelect_n <= 1'b1;
			act <= 1'b0;
			drvOn <= 1'b0;
			repeat (4) @(posedge clock);
		end
	endtask
endmodule

/* File: bench/hpi_host_port_tb.sv */
`timescale 1ns/10ps
`include "hpi_map.vh"
module hpi_host_port_tb;
	reg		clock = 0, rst = 1, cpuFamilySelect = 0, syncMode = 0;
	reg		dividerSelect = 1, intPolarityHigh = 1, interruptRequest = 0;
	reg		outputFloatTest_n = 1, factoryTest_n = 1, seqReq = 0;
	reg		seqWrite = 0, ok;
	reg [10:0]	seqAddr = 0, a;
	reg [7:0]	seqWdata = 0, q, sq;
	wire [10:0]	hostAddressBus;
	wire [7:0]	hostDataIn, hostDataOut, seqRdata;
	wire		hostDataOe, chipSelect_n, addressLatchStrobe, seqAck;
	wire		writeStrobeOrEclk, readStrobeOrDirection, accessReadyOe;
	wire		accessReadyOut, dividedClockOut, dividedClockOe;
	wire		interruptOut, interruptOe, factoryTestActive;
	wire		mux = !cpuFamilySelect && syncMode;
	integer		n_mismatch = 0, num_checks = 0, cyc = 0, m, i;
	hpi_host_port dut (.*);
	hpi_host_model host (.*);
	always #4 clock = ~clock;
	task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch %0s exp %h got %h", what, exp, got);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task set_mode(input [1:0] code);
		begin
			cpuFamilySelect <= code[1];
			syncMode <= code[1] ~^ code[0];
		end
	endtask
	task t_modes;
		for (m = 0; m < 4; m = m + 1) begin
			set_mode(m[1:0]);
			a = m == 0 ? 11'h503 : 11'h1a0 + m[10:0];
			host.access(1'b1, a, 8'h5a ^ m[7:0], 1'b1, m == 1 || m == 2, q, ok);
			chk("wr_ok", 8'h01, {7'h0, ok});
			host.access(1'b0, a, 8'h00, 1'b1, m == 1 || m == 2, q, ok);
			chk("rd_data", 8'h5a ^ m[7:0], q);
		end
	endtask
	task t_refuse;
		begin
			set_mode(`HPI_MODE_ASYNC_STROBE);
			host.access(1'b1, 11'h04b, 8'h11, 1'b1, 1'b1, q, ok);
			host.access(1'b1, 11'h04b, 8'h99, 1'b0, 1'b1, q, ok);
			chk("unsel", 8'h00, {7'h0, ok});
			set_mode(`HPI_MODE_SYNC_STROBE);
			host.access(1'b1, 11'h04b, 8'hc3, 1'b1, 1'b0, q, ok);
			set_mode(`HPI_MODE_ASYNC_STROBE);
			host.access(1'b0, 11'h04b, 8'h00, 1'b1, 1'b1, q, ok);
			chk("refused", 8'h11, q);
		end
	endtask
	task t_arb;
		begin
			set_mode(`HPI_MODE_ASYNC_ECLK);
			host.access(1'b1, 11'h5ff, 8'h3c, 1'b1, 1'b1, q, ok);
			fork
				host.access(1'b0, 11'h5ff, 8'h00, 1'b1, 1'b1, q, ok);
				begin
					// First seen in the host's RAM cycle, so it must wait
					repeat (10) @(posedge clock);
					seqReq <= 1'b1;
					seqAddr <= 11'h5ff;
					for (i = 0; i < 30 && seqAck !== 1'b1; i = i + 1)
						@(posedge clock);
					sq = seqRdata;
					seqReq <= 1'b0;
				end
			join
			chk("host_rd", 8'h3c, q);
			chk("seq_rd", 8'h3c, sq);
			chk("seq_wait", 8'h03, i[7:0]);
		end
	endtask
	task t_pins;
		begin
			outputFloatTest_n <= 1'b0;
			interruptRequest <= 1'b1;
			host.access(1'b0, 11'h5ff, 8'h00, 1'b1, 1'b1, q, ok);
			chk("float", 8'h00, {7'h0, ok});
			outputFloatTest_n <= 1'b1;
			intPolarityHigh <= 1'b0;
			dividerSelect <= 1'b0;
			factoryTest_n <= 1'b0;
			repeat (20) @(posedge clock);
			chk("ftest", 8'h01, {7'h0, factoryTestActive});
			chk("irq_out", 8'h00, {7'h0, interruptOut});
			chk("div_oe", 8'h01, {7'h0, dividedClockOe});
			factoryTest_n <= 1'b1;
		end
	endtask
	initial begin
		repeat (16) @(posedge clock);
		chk("rst_oe", 8'h00, {7'h0, hostDataOe});
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		t_modes;
		t_refuse;
		t_arb;
		t_pins;
		wrap_up;
	end
	// Cuts a hung handshake short
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			wrap_up;
		end
	end
endmodule
